// ===== hw/nfcth_cfg.svh
// constants of the tag command handler and its reader end
// assumes a 100 MHz core clock shared by both ends
`ifndef NFCTH_CFG_SVH
`define NFCTH_CFG_SVH
`define NFCTH_CMD_VER     8'h60
`define NFCTH_CMD_SIG     8'h3C
`define NFCTH_CMD_PWD     8'h1B
`define NFCTH_CMD_READ    8'h30
`define NFCTH_SIG_ARG     8'h00
`define NFCTH_ACK         4'hA
`define NFCTH_NAK_ARG     4'h0
`define NFCTH_NAK_CRC     4'h1
`define NFCTH_NAK_LIM     4'h4
`define NFCTH_CRC_INIT    16'h6363
`define NFCTH_CRC_POLY    16'h8408
`define NFCTH_VER_HDR     8'h00
`define NFCTH_VER_PROTO   8'h03
`define NFCTH_S0_LAST     8'hE9
`define NFCTH_S0_EXTRA_A  8'hEC
`define NFCTH_S0_EXTRA_B  8'hED
`define NFCTH_SRAM_FIRST  8'hF0
`define NFCTH_CLK_NS      10
`define NFCTH_FDT_NS      86430
`define NFCTH_TIMEOUT_NS  5000000
`define NFCTH_REG_CTRL    8'h00
`define NFCTH_REG_ARG     8'h04
`define NFCTH_REG_STAT    8'h08
`define NFCTH_REG_RXBUF   8'h20
`define NFCTH_REG_RXEND   8'h44
`define NFCTH_CTRL_GO     0
`define NFCTH_CTRL_CMD    1
`define NFCTH_CTRL_BADCRC 3
`define NFCTH_CTRL_PARERR 4
`define NFCTH_STAT_BUSY   0
`define NFCTH_STAT_DONE   1
`define NFCTH_STAT_TMO    2
`define NFCTH_STAT_SHORT  3
`define NFCTH_STAT_CODE   4
`define NFCTH_STAT_CRCOK  8
`define NFCTH_STAT_RXCNT  16
`endif

// ===== hw/nfcth_pkg.sv
// types and the frame checksum step shared by both ends
// assumes nothing beyond the constants header
`include "nfcth_cfg.svh"
package nfcth_pkg;
  typedef enum logic [1:0] {CMD_VER = 2'b00, CMD_SIG = 2'b01, CMD_PWD = 2'b10, CMD_READ = 2'b11} nfcth_cmd_e;
  typedef enum logic [2:0] {ST_RX = 3'b000, ST_DEC = 3'b001, ST_FETCH = 3'b010, ST_WAIT = 3'b011,
                            ST_SEND = 3'b100} nfcth_tstate_e;
  typedef enum logic [2:0] {RSP_VER = 3'b000, RSP_SIG = 3'b001, RSP_PASSWORD_ACK_VALUE = 3'b010, RSP_READ = 3'b011,
                            RSP_SHORT = 3'b100} nfcth_rsp_e;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_TX = 2'b01, R_RX = 2'b10} nfcth_rstate_e;

  // one byte of the reflected type A checksum, lsb first
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `NFCTH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ===== hw/nfcth_link_if.sv
// byte level contactless link between reader end and tag end
// assumes both ends share core_clk; one byte per valid cycle
`timescale 1ns/1ps
`default_nettype none
interface nfcth_link_if (input wire logic core_clk);
  logic       cmdValid;
  logic [7:0] cmdByte;
  logic       cmdEnd;
  logic       cmdParErr;
  logic       rspValid;
  logic [7:0] rspByte;
  logic       rspEnd;
  logic       rspShort;
  modport tag (input cmdValid, cmdByte, cmdEnd, cmdParErr, output rspValid, rspByte, rspEnd, rspShort);
  modport reader (output cmdValid, cmdByte, cmdEnd, cmdParErr, input rspValid, rspByte, rspEnd, rspShort);
endinterface
`default_nettype wire

// ===== hw/nfcth_tag_end.sv
// tag end: interprets version, signature, password and read frames
// assumes page memory reads combinationally from memPage/memSector
`timescale 1ns/1ps
`include "nfcth_cfg.svh"
`default_nettype none
module nfcth_tag_end #(
  parameter int             FDT_CYC      = (`NFCTH_FDT_NS + `NFCTH_CLK_NS - 1) / `NFCTH_CLK_NS,
  parameter logic [7:0]     VENDOR_ID    = 8'h5A,  // arbitrary value
  parameter logic [7:0]     PROD_TYPE    = 8'hA1,  // arbitrary value
  parameter logic [7:0]     PROD_SUBTYPE = 8'hB2,  // arbitrary value
  parameter logic [7:0]     VER_MAJOR    = 8'h01,  // arbitrary value
  parameter logic [7:0]     VER_MINOR    = 8'h00,  // arbitrary value
  parameter logic [6:0]     SIZE_EXP     = 7'h0A,
  parameter logic           SIZE_INEXACT = 1'b1,
  parameter logic [255:0]   SIGNATURE    = {8{32'hC0DE5EED}}  // arbitrary value
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  nfcth_link_if.tag         lnk,
  input  wire logic         deselect,
  input  wire logic         variant2k,
  input  wire logic         sectorSel,
  input  wire logic         passThrough,
  input  wire logic [7:0]   protectStartPage,
  input  wire logic         protectLevelSelect,
  input  wire logic [2:0]   failedTryLimit,
  input  wire logic [31:0]  password,
  input  wire logic [15:0]  passwordAckValue,
  output logic [7:0]        memPage,
  output logic              memSector,
  input  wire logic [31:0]  memData,
  output logic              authOk,
  output logic              triesLocked,
  output logic              protectWriteOk
);
  nfcth_pkg::nfcth_tstate_e state;
  nfcth_pkg::nfcth_rsp_e    rspKind;
  logic [7:0]  rxBuf [0:6];
  logic [3:0]  rxCnt;
  logic [15:0] rxCrc;
  logic        parSeen;
  logic        crcBad;
  logic [15:0] dlyCnt;
  logic [7:0]  failCnt;
  logic [31:0] rdWord [0:3];
  logic [2:0]  fIdx;
  logic [3:0]  okMask;
  logic [5:0]  txIdx;
  logic [5:0]  txLen;
  logic [15:0] txCrc;
  logic [3:0]  shortCode;

  // decode of the received frame
  wire logic [15:0] crcIn     = nfcth_pkg::crcStep(rxCrc, lnk.cmdByte);
  wire logic [8:0]  failLimit = 9'h001 << failedTryLimit;
  wire logic        locked    = (failedTryLimit != 3'h0) && ({1'b0, failCnt} >= failLimit);
  wire logic        pwdMatch  = {rxBuf[1], rxBuf[2], rxBuf[3], rxBuf[4]} == password;
  wire logic [8:0]  fetchPage = {1'b0, rxBuf[1]} + {6'h00, fIdx};
  wire logic [63:0] verBlock  = {`NFCTH_VER_PROTO, SIZE_EXP, SIZE_INEXACT, VER_MINOR, VER_MAJOR,
                                 PROD_SUBTYPE, PROD_TYPE, VENDOR_ID, `NFCTH_VER_HDR};
  wire logic        fetchDone = fIdx == 3'h4;

  // page reachable: range per sector, then the read guard of the protected area
  function automatic logic pageReadable(input logic [8:0] p);
    logic inRange;
    logic guarded;
    inRange = sectorSel ? variant2k
            : (p[7:0] <= `NFCTH_S0_LAST || p[7:0] == `NFCTH_S0_EXTRA_A
               || p[7:0] == `NFCTH_S0_EXTRA_B || (passThrough && p[7:0] >= `NFCTH_SRAM_FIRST));
    guarded = (p[7:0] >= protectStartPage) && protectLevelSelect && (!authOk || locked);
    return !p[8] && inRange && !guarded;
  endfunction

  // outgoing data byte; every block goes out byte 0 first
  logic [7:0] dataByte;
  always_comb begin
    unique case (rspKind)
      nfcth_pkg::RSP_VER:  dataByte = verBlock[{txIdx[2:0], 3'b000} +: 8];
      nfcth_pkg::RSP_SIG:  dataByte = SIGNATURE[{txIdx[4:0], 3'b000} +: 8];
      nfcth_pkg::RSP_PASSWORD_ACK_VALUE: dataByte = passwordAckValue[{txIdx[0], 3'b000} +: 8];
      nfcth_pkg::RSP_READ: dataByte = rdWord[txIdx[3:2]][{txIdx[1:0], 3'b000} +: 8];
      default:             dataByte = 8'h00;
    endcase
  end

  // receive: gather bytes and running checksum until the frame end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxCnt   <= 4'h0;
      rxCrc   <= `NFCTH_CRC_INIT;
      parSeen <= 1'b0;
      crcBad  <= 1'b0;
      for (int i = 0; i < 7; i++) rxBuf[i] <= 8'h00;
    end else if (state == nfcth_pkg::ST_DEC || deselect) begin
      rxCnt   <= 4'h0;
      rxCrc   <= `NFCTH_CRC_INIT;
      parSeen <= 1'b0;
    end else if (state == nfcth_pkg::ST_RX && lnk.cmdValid) begin
      if (rxCnt < 4'h7) rxBuf[rxCnt[2:0]] <= lnk.cmdByte;
      if (rxCnt != 4'hF) rxCnt <= rxCnt + 4'h1;
      rxCrc   <= crcIn;
      parSeen <= parSeen | lnk.cmdParErr;
      if (lnk.cmdEnd) crcBad <= (crcIn != 16'h0000) | parSeen | lnk.cmdParErr;
    end
  end

  // frame delay counter, restarted by every frame end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) dlyCnt <= 16'h0000;
    else if (lnk.cmdValid && lnk.cmdEnd) dlyCnt <= 16'h0000;
    else if (dlyCnt != 16'hFFFF) dlyCnt <= dlyCnt + 16'h0001;
  end

  // command decision, fetch, delay and reply sequencing
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= nfcth_pkg::ST_RX;
      rspKind   <= nfcth_pkg::RSP_SHORT;
      shortCode <= `NFCTH_NAK_ARG;
      txLen     <= 6'h00;
      authOk    <= 1'b0;
      failCnt   <= 8'h00;
    end else if (deselect) begin
      state  <= nfcth_pkg::ST_RX;
      authOk <= 1'b0;
    end else begin
      unique case (state)
        nfcth_pkg::ST_RX: if (lnk.cmdValid && lnk.cmdEnd) state <= nfcth_pkg::ST_DEC;
        nfcth_pkg::ST_DEC: begin
          state     <= nfcth_pkg::ST_WAIT;
          rspKind   <= nfcth_pkg::RSP_SHORT;
          shortCode <= `NFCTH_NAK_ARG;
          if (crcBad) begin
            shortCode <= `NFCTH_NAK_CRC;
          end else if (rxBuf[0] == `NFCTH_CMD_VER && rxCnt == 4'h3) begin
            rspKind <= nfcth_pkg::RSP_VER;
            txLen   <= 6'd8;
          end else if (rxBuf[0] == `NFCTH_CMD_SIG && rxCnt == 4'h4 && rxBuf[1] == `NFCTH_SIG_ARG) begin
            rspKind <= nfcth_pkg::RSP_SIG;
            txLen   <= 6'd32;
          end else if (rxBuf[0] == `NFCTH_CMD_PWD && rxCnt == 4'h7) begin
            if (locked) begin
              shortCode <= `NFCTH_NAK_LIM;
            end else if (pwdMatch) begin
              rspKind <= nfcth_pkg::RSP_PASSWORD_ACK_VALUE;
              txLen   <= 6'd2;
              authOk  <= 1'b1;
              failCnt <= 8'h00;
            end else if (failedTryLimit != 3'h0 && failCnt != 8'hFF) begin
              failCnt <= failCnt + 8'h01;
            end
          end else if (rxBuf[0] == `NFCTH_CMD_READ && rxCnt == 4'h4) begin
            if (pageReadable({1'b0, rxBuf[1]})) begin
              state   <= nfcth_pkg::ST_FETCH;
              rspKind <= nfcth_pkg::RSP_READ;
              txLen   <= 6'd16;
            end
          end
        end
        nfcth_pkg::ST_FETCH: if (fetchDone) state <= nfcth_pkg::ST_WAIT;
        nfcth_pkg::ST_WAIT: if ({16'h0000, dlyCnt} >= FDT_CYC - 1) state <= nfcth_pkg::ST_SEND;
        nfcth_pkg::ST_SEND: begin
          if (rspKind == nfcth_pkg::RSP_SHORT || txIdx == txLen + 6'h01) state <= nfcth_pkg::ST_RX;
        end
      endcase
    end
  end

  // four page fetch: address one cycle, capture the next
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fIdx      <= 3'h0;
      okMask    <= 4'h0;
      memPage   <= 8'h00;
      memSector <= 1'b0;
      for (int i = 0; i < 4; i++) rdWord[i] <= 32'h0000_0000;
    end else if (state == nfcth_pkg::ST_FETCH && !fetchDone) begin
      fIdx      <= fIdx + 3'h1;
      memPage   <= fetchPage[7:0];
      memSector <= sectorSel;
      okMask[fIdx[1:0]] <= pageReadable(fetchPage);
      if (fIdx != 3'h0) rdWord[fIdx[1:0] - 2'h1] <= okMask[fIdx[1:0] - 2'h1] ? memData : 32'h0000_0000;
    end else if (state == nfcth_pkg::ST_FETCH) begin
      rdWord[3] <= okMask[3] ? memData : 32'h0000_0000;
    end else begin
      fIdx <= 3'h0;
    end
  end

  // reply shifter: data bytes, then checksum low and high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lnk.rspValid <= 1'b0;
      lnk.rspByte  <= 8'h00;
      lnk.rspEnd   <= 1'b0;
      lnk.rspShort <= 1'b0;
      txIdx        <= 6'h00;
      txCrc        <= `NFCTH_CRC_INIT;
    end else if (state == nfcth_pkg::ST_SEND && !deselect) begin
      lnk.rspValid <= 1'b1;
      txIdx        <= txIdx + 6'h01;
      if (rspKind == nfcth_pkg::RSP_SHORT) begin
        lnk.rspByte  <= {4'h0, shortCode};
        lnk.rspShort <= 1'b1;
        lnk.rspEnd   <= 1'b1;
      end else if (txIdx < txLen) begin
        lnk.rspByte <= dataByte;
        txCrc       <= nfcth_pkg::crcStep(txCrc, dataByte);
      end else if (txIdx == txLen) begin
        lnk.rspByte <= txCrc[7:0];
      end else begin
        lnk.rspByte <= txCrc[15:8];
        lnk.rspEnd  <= 1'b1;
      end
    end else begin
      lnk.rspValid <= 1'b0;
      lnk.rspEnd   <= 1'b0;
      lnk.rspShort <= 1'b0;
      txIdx        <= 6'h00;
      txCrc        <= `NFCTH_CRC_INIT;
    end
  end

  // status flags; write access to the protected area needs auth and no lockout
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      triesLocked    <= 1'b0;
      protectWriteOk <= 1'b0;
    end else begin
      triesLocked    <= locked;
      protectWriteOk <= authOk && !locked;
    end
  end
endmodule
`default_nettype wire

// ===== hw/nfcth_reader_end.sv
// reader end: software orders one frame over AHB-Lite, gets the reply
// assumes a single AHB-Lite master, word transfers only
`timescale 1ns/1ps
`include "nfcth_cfg.svh"
`default_nettype none
module nfcth_reader_end #(
  parameter int TIMEOUT_CYC = `NFCTH_TIMEOUT_NS / `NFCTH_CLK_NS
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  nfcth_link_if.reader     lnk
);
  nfcth_pkg::nfcth_rstate_e state;
  logic [4:0]  ctrlReg;
  logic [31:0] argReg;
  logic        done, tmo, gotShort, crcOk;
  logic [3:0]  code;
  logic [7:0]  txBuf [0:4];
  logic [2:0]  txLen, txIdx;
  logic [15:0] txCrc, rxCrc;
  logic [7:0]  rxBuf [0:35];
  logic [5:0]  rxCnt;
  logic [31:0] tmoCnt;
  logic        wrPend;
  logic [7:0]  wrAddr;

  // bus decode; reads answer in the data phase from a flop
  wire logic        addrOk  = hsel && hready && htrans[1] && hsize == 3'b010;
  wire logic        busy    = state != nfcth_pkg::R_IDLE;
  wire logic        goWr    = wrPend && wrAddr == `NFCTH_REG_CTRL && hwdata[`NFCTH_CTRL_GO] && !busy;
  wire logic [7:0]  rxOff   = haddr - `NFCTH_REG_RXBUF;
  wire logic [5:0]  rxBase  = {rxOff[5:2], 2'b00};
  wire logic [31:0] statWord = {10'h000, rxCnt, 7'h00, crcOk, code, gotShort, tmo, done, busy};
  wire logic [15:0] txCrcNx = nfcth_pkg::crcStep(txCrc, txBuf[txIdx]);
  wire logic [15:0] rxCrcNx = nfcth_pkg::crcStep(rxCrc, lnk.rspByte);
  logic [31:0] rdMux;
  always_comb begin
    if (haddr == `NFCTH_REG_CTRL) rdMux = {27'h0, ctrlReg};
    else if (haddr == `NFCTH_REG_ARG) rdMux = argReg;
    else if (haddr == `NFCTH_REG_STAT) rdMux = statWord;
    else if (haddr >= `NFCTH_REG_RXBUF && haddr < `NFCTH_REG_RXEND)
      rdMux = {rxBuf[rxBase + 6'd3], rxBuf[rxBase + 6'd2], rxBuf[rxBase + 6'd1], rxBuf[rxBase]};
    else rdMux = 32'h0000_0000;
  end

  // zero wait state slave, always OKAY
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      ctrlReg   <= 5'h00;
      argReg    <= 32'h0000_0000;
    end else begin
      wrPend <= addrOk && hwrite;
      if (addrOk) wrAddr <= haddr;
      if (addrOk && !hwrite) hrdata <= rdMux;
      if (wrPend && wrAddr == `NFCTH_REG_CTRL) ctrlReg <= {hwdata[4:1], 1'b0};  // go bit self clears
      if (wrPend && wrAddr == `NFCTH_REG_ARG) argReg <= hwdata;
    end
  end

  // frame build, send, then wait for the reply or the timeout
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= nfcth_pkg::R_IDLE;
      {done, tmo, gotShort, crcOk, code} <= 8'h00;
      {txLen, txIdx, rxCnt} <= 12'h000;
      txCrc <= `NFCTH_CRC_INIT;
      rxCrc <= `NFCTH_CRC_INIT;
      tmoCnt <= 32'h0000_0000;
      {lnk.cmdValid, lnk.cmdEnd, lnk.cmdParErr} <= 3'b000;
      lnk.cmdByte <= 8'h00;
      for (int i = 0; i < 5; i++) txBuf[i] <= 8'h00;
      for (int i = 0; i < 36; i++) rxBuf[i] <= 8'h00;
    end else begin
      {lnk.cmdValid, lnk.cmdEnd, lnk.cmdParErr} <= 3'b000;
      unique case (state)
        nfcth_pkg::R_IDLE: if (goWr) begin
          state <= nfcth_pkg::R_TX;
          {done, tmo, gotShort, crcOk} <= 4'h0;
          {txIdx, rxCnt} <= 9'h000;
          txCrc <= `NFCTH_CRC_INIT;
          rxCrc <= `NFCTH_CRC_INIT;
          unique case (nfcth_pkg::nfcth_cmd_e'(hwdata[2:1]))
            nfcth_pkg::CMD_VER: begin
              txBuf[0] <= `NFCTH_CMD_VER;
              txLen    <= 3'd1;
            end
            nfcth_pkg::CMD_SIG: begin
              txBuf[0] <= `NFCTH_CMD_SIG;
              txBuf[1] <= `NFCTH_SIG_ARG;
              txLen    <= 3'd2;
            end
            nfcth_pkg::CMD_PWD: begin
              txBuf[0] <= `NFCTH_CMD_PWD;
              {txBuf[1], txBuf[2], txBuf[3], txBuf[4]} <= argReg;
              txLen    <= 3'd5;
            end
            nfcth_pkg::CMD_READ: begin
              txBuf[0] <= `NFCTH_CMD_READ;
              txBuf[1] <= argReg[7:0];
              txLen    <= 3'd2;
            end
          endcase
        end
        nfcth_pkg::R_TX: begin
          lnk.cmdValid <= 1'b1;
          txIdx <= txIdx + 3'd1;
          if (txIdx < txLen) begin
            lnk.cmdByte <= txBuf[txIdx];
            txCrc <= txCrcNx;
          end else if (txIdx == txLen) begin
            lnk.cmdByte <= txCrc[7:0] ^ {8{ctrlReg[`NFCTH_CTRL_BADCRC]}};
          end else begin
            lnk.cmdByte   <= txCrc[15:8];
            lnk.cmdEnd    <= 1'b1;
            lnk.cmdParErr <= ctrlReg[`NFCTH_CTRL_PARERR];
            tmoCnt <= 32'h0000_0000;
            state <= nfcth_pkg::R_RX;
          end
        end
        nfcth_pkg::R_RX: begin
          tmoCnt <= tmoCnt + 32'h0000_0001;
          if (lnk.rspValid) begin
            if (rxCnt < 6'd36) rxBuf[rxCnt] <= lnk.rspByte;
            if (rxCnt != 6'h3F) rxCnt <= rxCnt + 6'd1;
            rxCrc <= rxCrcNx;
            if (lnk.rspEnd) begin
              state    <= nfcth_pkg::R_IDLE;
              done     <= 1'b1;
              gotShort <= lnk.rspShort;
              code     <= lnk.rspShort ? lnk.rspByte[3:0] : `NFCTH_ACK;
              crcOk    <= !lnk.rspShort && rxCrcNx == 16'h0000;
            end
          end else if (tmoCnt >= 32'(TIMEOUT_CYC - 1)) begin
            state <= nfcth_pkg::R_IDLE;
            done  <= 1'b1;
            tmo   <= 1'b1;
          end
        end
        default: state <= nfcth_pkg::R_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/nfcth_checker.sv
// concurrent checks on the byte link joining the reader end and the tag end
// assumes both ends run on core_clk with the shared async active-low rstn
`timescale 1ns/1ps
`default_nettype none
module nfcth_checker #(
  parameter int FDT_CYC = 8643
) (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic       cmdEnd,
  input wire logic       cmdParErr,
  input wire logic       rspValid,
  input wire logic [7:0] rspByte,
  input wire logic       rspEnd,
  input wire logic       rspShort
);
  // slack above the frame delay covers the fetch and decode cycles
  localparam int FDT_HI = FDT_CYC + 12;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] gapCnt_reg;
  logic [5:0]  rspCnt_reg;
  // gap since frame end saturates, so a long idle never wraps into a false early reply
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_reg <= 16'hFFFF;
      rspCnt_reg <= 6'h00;
    end else begin
      if (cmdValid && cmdEnd) begin
        gapCnt_reg <= 16'h0001;
      end else if (gapCnt_reg != 16'hFFFF) begin
        gapCnt_reg <= gapCnt_reg + 16'h0001;
      end
      if (rspValid) begin
        rspCnt_reg <= rspEnd ? 6'h00 : rspCnt_reg + 6'h01;
      end
    end
  end
  property p_reply_late; $rose(rspValid) |-> gapCnt_reg >= FDT_CYC; endproperty
  a_reply_late: assert property (p_reply_late) else $error("reply began before the frame delay");
  property p_reply_window; cmdValid && cmdEnd |-> ##[FDT_CYC:FDT_HI] rspValid; endproperty
  a_reply_window: assert property (p_reply_window) else $error("no reply after a frame");
  property p_par_nak; cmdValid && cmdEnd && cmdParErr |-> ##[FDT_CYC:FDT_HI] (rspShort && rspByte == 8'h01); endproperty
  a_par_nak: assert property (p_par_nak) else $error("parity fault not answered with code 1");
  property p_short_whole; rspShort |-> rspValid && rspEnd && rspCnt_reg == 6'h00; endproperty
  a_short_whole: assert property (p_short_whole) else $error("short reply not a single unit");
  property p_short_code; rspValid && rspShort |-> rspByte inside {8'h00, 8'h01, 8'h04}; endproperty
  a_short_code: assert property (p_short_code) else $error("short reply code out of set");
  property p_rsp_run; rspValid && !rspEnd |=> rspValid; endproperty
  a_rsp_run: assert property (p_rsp_run) else $error("gap inside a reply");
  property p_data_len; rspValid && rspEnd && !rspShort |-> rspCnt_reg inside {6'h03, 6'h09, 6'h11, 6'h21}; endproperty
  a_data_len: assert property (p_data_len) else $error("data reply length wrong");
  property p_cmd_run; cmdValid && !cmdEnd |=> cmdValid; endproperty
  a_cmd_run: assert property (p_cmd_run) else $error("gap inside a command frame");
  property p_cmd_code; $rose(cmdValid) |-> cmdByte inside {8'h60, 8'h3C, 8'h1B, 8'h30}; endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("unknown command code");
  property p_one_way; rspValid |-> !cmdValid; endproperty
  a_one_way: assert property (p_one_way) else $error("both directions active at once");
  c_read_reply: cover property (rspValid && rspEnd && rspCnt_reg == 6'h11);
  c_short_reply: cover property (rspShort);
  c_parity_frame: cover property (cmdValid && cmdEnd && cmdParErr);
endmodule
`default_nettype wire

// ===== test/nfc_tag_command_handler_bench.sv
// bench: reader end and tag end joined by the link, frames ordered over AHB-Lite
// assumes the hw files; the page memory is modelled here as a pattern of page and sector
`timescale 1ns/1ps
`include "nfcth_cfg.svh"
`default_nettype none
module nfc_tag_command_handler_bench;
  localparam int FDT = 20;
  localparam logic [31:0] FULL = 32'hFFFFFFFF;
  logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010, failedTryLimit = 3'h0;
  logic [7:0] haddr = 8'h00, protectStartPage = 8'h10, memPage;
  logic [31:0] hwdata = 32'h0, hrdata, rdat, stat, password = 32'h11223344;
  logic [15:0] passwordAckValue = 16'hBEEF;
  logic deselect = 1'b0, variant2k = 1'b0, sectorSel = 1'b0, passThrough = 1'b0, protectLevelSelect = 1'b0;
  logic memSector, authOk, triesLocked, protectWriteOk;
  int errors = 0;
  int comparisons = 0;
  // page pattern differs per sector so a wrong sector shows up in the data
  function automatic logic [31:0] pw(input logic [7:0] p, input logic s);
    logic [7:0] b;
    b = {p[5:0], 2'b00};
    return {b + 8'h03, b + 8'h02, b + 8'h01, b} ^ {4{s ? 8'h77 : 8'h00}};
  endfunction
  wire logic [31:0] memData;
  assign memData = pw(memPage, memSector);
  always #5 core_clk = ~core_clk;
  nfcth_link_if nfcth_link_if_i (.core_clk(core_clk));
  nfcth_reader_end #(.TIMEOUT_CYC(2000)) nfcth_reader_end_i (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lnk(nfcth_link_if_i));
  nfcth_tag_end #(.FDT_CYC(FDT)) nfcth_tag_end_i (.core_clk(core_clk), .rstn(rstn), .lnk(nfcth_link_if_i),
    .deselect(deselect), .variant2k(variant2k), .sectorSel(sectorSel), .passThrough(passThrough),
    .protectStartPage(protectStartPage), .protectLevelSelect(protectLevelSelect), .failedTryLimit(failedTryLimit),
    .password(password), .passwordAckValue(passwordAckValue), .memPage(memPage), .memSector(memSector),
    .memData(memData), .authOk(authOk), .triesLocked(triesLocked), .protectWriteOk(protectWriteOk));
  nfcth_checker #(.FDT_CYC(FDT)) nfcth_checker_i (.core_clk(core_clk), .rstn(rstn),
    .cmdValid(nfcth_link_if_i.cmdValid), .cmdByte(nfcth_link_if_i.cmdByte), .cmdEnd(nfcth_link_if_i.cmdEnd),
    .cmdParErr(nfcth_link_if_i.cmdParErr), .rspValid(nfcth_link_if_i.rspValid), .rspByte(nfcth_link_if_i.rspByte),
    .rspEnd(nfcth_link_if_i.rspEnd), .rspShort(nfcth_link_if_i.rspShort));
  task automatic close_out();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single word transfer; address phase held until hready, read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rdat = hrdata;
    chk(hresp, 1'b0);
  endtask
  // order one frame and poll status until the reply is in, bounded
  task automatic run(input logic [1:0] c, input logic [31:0] arg, input logic [1:0] fl);
    bus(1'b1, `NFCTH_REG_ARG, arg);
    bus(1'b1, `NFCTH_REG_CTRL, {27'h0, fl, c, 1'b1});
    stat = 32'h0;
    for (int i = 0; i < 300 && stat[`NFCTH_STAT_DONE] !== 1'b1; i++) begin
      bus(1'b0, `NFCTH_REG_STAT, 32'h0);
      stat = rdat;
    end
    chk(stat[`NFCTH_STAT_DONE], 1'b1);
  endtask
  // status low byte also shows idle, done and no timeout
  task automatic okd();
    chk({stat[`NFCTH_STAT_CRCOK], stat[7:0]}, {1'b1, `NFCTH_ACK, 4'h2});
  endtask
  task automatic nak(input logic [3:0] c);
    chk(stat[7:0], {c, 4'hA});
  endtask
  task automatic rx(input int k, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, `NFCTH_REG_RXBUF + 8'(4 * k), 32'h0);
    chk(rdat & m, e);
  endtask
  // n is the count of readable pages from p; zero means the start page is refused
  task automatic rd(input logic [7:0] p, input int n);
    run(nfcth_pkg::CMD_READ, {24'h0, p}, 2'b00);
    if (n == 0) begin
      nak(`NFCTH_NAK_ARG);
    end else begin
      okd();
      chk(stat[`NFCTH_STAT_RXCNT +: 6], 32'h12);
      for (int k = 0; k < 4; k++) rx(k, k < n ? pw(p + 8'(k), sectorSel) : 32'h0, FULL);
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    run(nfcth_pkg::CMD_VER, 32'h0, 2'b00);
    okd();
    rx(0, {8'hB2, 8'hA1, 8'h5A, `NFCTH_VER_HDR}, FULL);
    rx(1, {`NFCTH_VER_PROTO, 7'h0A, 1'b1, 8'h00, 8'h01}, FULL);
    run(nfcth_pkg::CMD_SIG, 32'h0, 2'b00);
    okd();
    for (int k = 0; k < 8; k++) rx(k, 32'hC0DE5EED, FULL);
    run(nfcth_pkg::CMD_VER, 32'h0, 2'b01);
    nak(`NFCTH_NAK_CRC);
    run(nfcth_pkg::CMD_VER, 32'h0, 2'b10);
    nak(`NFCTH_NAK_CRC);
    rd(8'h03, 4);
    rd(8'hE8, 2);
    rd(8'hEC, 2);
    rd(8'hEA, 0);
    rd(8'hF0, 0);
    passThrough <= 1'b1;
    rd(8'hF0, 4);
    variant2k <= 1'b1;
    sectorSel <= 1'b1;
    rd(8'hFE, 2);
    variant2k <= 1'b0;
    rd(8'h00, 0);
    sectorSel <= 1'b0;
    passThrough <= 1'b0;
    protectLevelSelect <= 1'b1;
    rd(8'h10, 0);
    rd(8'h0E, 2);
    // wrong checks with no limit are never counted
    repeat (2) run(nfcth_pkg::CMD_PWD, password ^ 32'h1, 2'b00);
    nak(`NFCTH_NAK_ARG);
    chk(triesLocked, 1'b0);
    failedTryLimit <= 3'h1;
    run(nfcth_pkg::CMD_PWD, password, 2'b00);
    okd();
    rx(0, {16'h0, passwordAckValue}, 32'h0000FFFF);
    chk({authOk, protectWriteOk}, 2'b11);
    rd(8'h10, 4);
    deselect <= 1'b1;
    @(posedge core_clk);
    deselect <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(authOk, 1'b0);
    rd(8'h10, 0);
    run(nfcth_pkg::CMD_PWD, password ^ 32'h1, 2'b00);
    chk(triesLocked, 1'b0);
    run(nfcth_pkg::CMD_PWD, password ^ 32'h1, 2'b00);
    chk(triesLocked, 1'b1);
    run(nfcth_pkg::CMD_PWD, password, 2'b00);
    nak(`NFCTH_NAK_LIM);
    rd(8'h10, 0);
    close_out();
  end
  // twenty-three frames of under two hundred cycles each; this bound leaves tenfold margin
  initial begin
    #500000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
